// File: rtl/awrc_top.v
// command interpreter, address watch and run control
`timescale 1ns/1ps
`default_nettype none
`include "awrc_defs.vh"
module awrc_top
(
  input wire clk,
  input wire rst,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire tx_ready,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire [15:0] bus_addr,
  input wire bus_valid,
  input wire instr_done,
  input wire [15:0] instr_addr,
  input wire brk_hit,
  input wire [15:0] brk_addr,
  input wire wai_seen,
  input wire irq_unmasked,
  input wire [15:0] reg_pc,
  input wire [15:0] reg_x,
  input wire [7:0] reg_a,
  input wire [7:0] reg_b,
  input wire [7:0] reg_cc,
  input wire [15:0] reg_sp,
  input wire scope_switch_pin,
  input wire abort_switch_pin,
  output reg sync_trigger,
  output reg run_free,
  output reg step_one,
  output reg restart_irq,
  output reg pc_load,
  output reg [15:0] pc_value,
  output reg monitor_debug_mode
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_PRINT = 3'h2;
  localparam S_RUN = 3'h3;
  localparam S_HALT = 3'h4;
  localparam S_STEP = 3'h5;
  localparam S_STOP = 3'h6;
  localparam S_PROMPT = 3'h7;

  reg [2:0] state_reg;
  reg [2:0] after_reg;
  reg [15:0] num_reg;
  reg has_num_reg;
  reg dol_reg;
  reg semi_reg;
  reg [15:0] watch_addr_reg;
  reg watch_en_reg;
  reg [15:0] end_addr_reg;
  reg trace_end_reg;
  reg tmode_reg;
  reg tgt_end_reg;
  reg [15:0] cnt_reg;
  reg [15:0] bypass_reg;
  reg issued_reg;
  reg em_start_reg;
  reg [1:0] em_msg_reg;
  reg [71:0] em_data_reg;
  reg scope_s1_reg;
  reg scope_s2_reg;
  reg abort_s1_reg;
  reg abort_s2_reg;
  reg abort_s3_reg;
  wire em_done;
  wire abort_ev;
  wire watch_hit;
  wire is_hex;
  wire [3:0] hex_val;
  wire [71:0] dump_data;

  awrc_emit u_emit
  (
    .clk(clk),
    .rst(rst),
    .start(em_start_reg),
    .msg(em_msg_reg),
    .data(em_data_reg),
    .tx_ready(tx_ready),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .done(em_done)
  );

  // switches are asynchronous panel pins, so each passes two flops first
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scope_s1_reg <= 1'b0;
      scope_s2_reg <= 1'b0;
      abort_s1_reg <= 1'b0;
      abort_s2_reg <= 1'b0;
      abort_s3_reg <= 1'b0;
    end
    else
    begin
      scope_s1_reg <= scope_switch_pin;
      scope_s2_reg <= scope_s1_reg;
      abort_s1_reg <= abort_switch_pin;
      abort_s2_reg <= abort_s1_reg;
      abort_s3_reg <= abort_s2_reg;
    end
  end

  assign abort_ev = abort_s2_reg & ~abort_s3_reg;
  // one comparator serves both switch positions
  assign watch_hit = watch_en_reg && bus_valid && (bus_addr == watch_addr_reg);
  assign is_hex = ((rx_data >= 8'h30) && (rx_data <= 8'h39)) || ((rx_data >= 8'h41) && (rx_data <= 8'h46));
  assign hex_val = (rx_data <= 8'h39) ? rx_data[3:0] : (rx_data[3:0] + 4'h9);
  assign dump_data = {reg_pc, reg_x, reg_a, reg_b, reg_cc, reg_sp};

  // scope pulse never touches run control
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_trigger <= 1'b0;
    end
    else
    begin
      sync_trigger <= watch_hit && scope_s2_reg;
    end
  end

  task print;
    input [1:0] m;
    input [71:0] d;
    input [2:0] nxt;
    begin
      em_start_reg <= 1'b1;
      em_msg_reg <= m;
      em_data_reg <= d;
      after_reg <= nxt;
      state_reg <= S_PRINT;
    end
  endtask

  task stop_dump;
    begin
      run_free <= 1'b0;
      print(`AWRC_MSG_DUMP, dump_data, S_PROMPT);
    end
  endtask

  task go_user;
    begin
      issued_reg <= 1'b0;
      if (trace_end_reg)
      begin
        tmode_reg <= 1'b1;
        state_reg <= S_STEP;
      end
      else
      begin
        run_free <= 1'b1;
        state_reg <= S_RUN;
      end
    end
  endtask

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= S_PROMPT;
      after_reg <= S_IDLE;
      num_reg <= 16'h0000;
      has_num_reg <= 1'b0;
      dol_reg <= 1'b0;
      semi_reg <= 1'b0;
      watch_addr_reg <= `AWRC_WATCH_RESET;
      watch_en_reg <= 1'b0;
      end_addr_reg <= `AWRC_END_RESET;
      trace_end_reg <= 1'b0;
      tmode_reg <= 1'b0;
      tgt_end_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      bypass_reg <= 16'h0000;
      issued_reg <= 1'b0;
      em_start_reg <= 1'b0;
      em_msg_reg <= 2'h0;
      em_data_reg <= 72'h0;
      run_free <= 1'b0;
      step_one <= 1'b0;
      restart_irq <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= 16'h0000;
      monitor_debug_mode <= 1'b1;
    end
    else
    begin
      em_start_reg <= 1'b0;
      step_one <= 1'b0;
      restart_irq <= 1'b0;
      pc_load <= 1'b0;
      monitor_debug_mode <= !run_free && (state_reg != S_STEP) && (state_reg != S_HALT);
      case (state_reg)
        S_IDLE:
        begin
          if (rx_valid)
          begin
            if (is_hex)
            begin
              num_reg <= {num_reg[11:0], hex_val};
              has_num_reg <= 1'b1;
            end
            else
            begin
              dol_reg <= 1'b0;
              semi_reg <= 1'b0;
              has_num_reg <= 1'b0;
              num_reg <= 16'h0000;
              case (rx_data)
                `AWRC_CH_DOLLAR:
                  dol_reg <= 1'b1;
                `AWRC_CH_SEMI:
                begin
                  semi_reg <= 1'b1;
                  has_num_reg <= has_num_reg;
                  num_reg <= num_reg;
                end
                `AWRC_CH_S:
                begin
                  if (dol_reg)
                  begin
                    tgt_end_reg <= 1'b0;
                    num_reg <= watch_addr_reg;
                    print(`AWRC_MSG_STOP, {watch_addr_reg, 56'h0}, S_ADDR);
                  end
                  else
                  begin
                    watch_en_reg <= 1'b0;
                    state_reg <= S_PROMPT;
                  end
                end
                `AWRC_CH_T:
                begin
                  if (dol_reg)
                  begin
                    tgt_end_reg <= 1'b1;
                    num_reg <= end_addr_reg;
                    print(`AWRC_MSG_END, {end_addr_reg, 56'h0}, S_ADDR);
                  end
                  else
                  begin
                    trace_end_reg <= 1'b0;
                    state_reg <= S_PROMPT;
                  end
                end
                `AWRC_CH_G:
                begin
                  if (has_num_reg && semi_reg)
                  begin
                    pc_load <= 1'b1;
                    pc_value <= num_reg;
                  end
                  else
                  begin
                    restart_irq <= 1'b1;
                  end
                  go_user;
                end
                `AWRC_CH_P:
                begin
                  // saved program counter is left alone, so the cpu resumes where it stood
                  if (has_num_reg && semi_reg && !trace_end_reg)
                  begin
                    bypass_reg <= num_reg;
                  end
                  else
                  begin
                    bypass_reg <= 16'h0000;
                  end
                  go_user;
                end
                `AWRC_CH_N:
                begin
                  tmode_reg <= 1'b0;
                  issued_reg <= 1'b0;
                  // a count of zero still steps once rather than hanging
                  if (has_num_reg && semi_reg && (num_reg != 16'h0000))
                  begin
                    cnt_reg <= num_reg;
                  end
                  else
                  begin
                    cnt_reg <= 16'h0001;
                  end
                  state_reg <= S_STEP;
                end
                default:
                  state_reg <= S_PROMPT;
              endcase
            end
          end
        end
        S_ADDR:
        begin
          if (rx_valid)
          begin
            if (is_hex)
            begin
              // first digit replaces the shown address, so short entries keep no stale digits
              num_reg <= has_num_reg ? {num_reg[11:0], hex_val} : {12'h000, hex_val};
              has_num_reg <= 1'b1;
            end
            else if (rx_data == `AWRC_CH_CR)
            begin
              if (tgt_end_reg)
              begin
                end_addr_reg <= num_reg;
                trace_end_reg <= 1'b1;
              end
              else
              begin
                watch_addr_reg <= num_reg;
                watch_en_reg <= 1'b1;
              end
              state_reg <= S_PROMPT;
            end
          end
        end
        S_PRINT:
        begin
          if (em_done)
          begin
            state_reg <= after_reg;
          end
        end
        S_RUN:
        begin
          if (abort_ev)
          begin
            run_free <= 1'b0;
            state_reg <= S_PROMPT;
          end
          else if (brk_hit && (brk_addr != `AWRC_EMPTY_ADDR))
          begin
            if (bypass_reg > 16'h0001)
            begin
              bypass_reg <= bypass_reg - 16'h0001;
            end
            else
            begin
              bypass_reg <= 16'h0000;
              stop_dump;
            end
          end
          else if (watch_hit && !scope_s2_reg)
          begin
            state_reg <= S_STOP;
          end
          else if (wai_seen)
          begin
            run_free <= 1'b0;
            state_reg <= S_HALT;
          end
        end
        S_STOP:
        begin
          // the cpu keeps running until the current instruction completes
          if (abort_ev)
          begin
            run_free <= 1'b0;
            state_reg <= S_PROMPT;
          end
          else if (instr_done)
          begin
            stop_dump;
          end
        end
        S_HALT:
        begin
          if (abort_ev)
          begin
            state_reg <= S_PROMPT;
          end
          else if (irq_unmasked)
          begin
            run_free <= 1'b1;
            state_reg <= S_RUN;
          end
        end
        S_STEP:
        begin
          if (abort_ev)
          begin
            issued_reg <= 1'b0;
            state_reg <= S_PROMPT;
          end
          else if (!issued_reg)
          begin
            step_one <= 1'b1;
            issued_reg <= 1'b1;
          end
          else if (instr_done)
          begin
            issued_reg <= 1'b0;
            cnt_reg <= cnt_reg - 16'h0001;
            if (tmode_reg ? (instr_addr == end_addr_reg) : (cnt_reg <= 16'h0001))
            begin
              print(`AWRC_MSG_DUMP, dump_data, S_PROMPT);
            end
            else
            begin
              print(`AWRC_MSG_DUMP, dump_data, S_STEP);
            end
          end
        end
        S_PROMPT:
        begin
          dol_reg <= 1'b0;
          semi_reg <= 1'b0;
          has_num_reg <= 1'b0;
          num_reg <= 16'h0000;
          print(`AWRC_MSG_PROMPT, 72'h0, S_IDLE);
        end
        default:
          state_reg <= S_PROMPT;
      endcase
    end
  end
endmodule // awrc_top
`default_nettype wire

// File: rtl/awrc_defs.vh
// constants for the address watch and run control block
// Behaviour
// - stop mode: finish instruction, then return
// - scope mode: pulse sync output, keep running
// - set-watch: prompt, read hex, enable, asterisk
// - clear-watch: disable watching, asterisk prompt
// - plain go: restart interrupt, run from vector
// - addressed go: load program counter, run
// - proceed: resume from saved program counter
// - proceed count: bypass breakpoints until zero
// - run ends on breakpoint, watch, halt opcode
// - abort switch regains monitor control
// - free run at full speed, no interruption
// - trace prints register dump per instruction
// - single step: one instruction, dump, return
// - counted step: n dumps then asterisk
// - set-end: prompt, read hex, arm trace-to-end
// - armed go/proceed commands start tracing
// - trace-to-end dumps until end address executed
// - exit-trace disarms, asterisk prompt
// - address zero means empty breakpoint slot
`ifndef AWRC_DEFS_VH
`define AWRC_DEFS_VH

`define AWRC_CH_CR 8'h0d
`define AWRC_CH_DOLLAR 8'h24
`define AWRC_CH_SEMI 8'h3b
`define AWRC_CH_HASH 8'h23
`define AWRC_CH_G 8'h47
`define AWRC_CH_N 8'h4e
`define AWRC_CH_P 8'h50
`define AWRC_CH_S 8'h53
`define AWRC_CH_T 8'h54

`define AWRC_MSG_PROMPT 2'h0
`define AWRC_MSG_STOP 2'h1
`define AWRC_MSG_END 2'h2
`define AWRC_MSG_DUMP 2'h3

`define AWRC_TPL_PROMPT {272'h0, "\015\012*"}
`define AWRC_LEN_PROMPT 6'h03
`define AWRC_TPL_STOP {160'h0, "\015\012STOP ADDR #### "}
`define AWRC_LEN_STOP 6'h11
`define AWRC_TPL_END {168'h0, "\015\012END ADDR #### "}
`define AWRC_LEN_END 6'h10
`define AWRC_TPL_DUMP "\015\012P-#### X-#### A-## B-## C-## S-####"
`define AWRC_LEN_DUMP 6'h25

`define AWRC_EMPTY_ADDR 16'h0000
`define AWRC_WATCH_RESET 16'h0000
`define AWRC_END_RESET 16'h0000

`endif

// File: rtl/awrc_emit.v
// text emitter: prompts and register dumps from templates
`timescale 1ns/1ps
`default_nettype none
`include "awrc_defs.vh"
module awrc_emit
(
  input wire clk,
  input wire rst,
  input wire start,
  input wire [1:0] msg,
  input wire [71:0] data,
  input wire tx_ready,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg done
);
  reg busy_reg;
  reg [5:0] idx_reg;
  reg [1:0] msg_reg;
  reg [71:0] data_reg;
  reg [295:0] tpl;
  reg [5:0] len;
  wire [5:0] pos;
  wire [7:0] tch;
  wire [3:0] nib;
  wire [7:0] hch;

  always @*
  begin
    case (msg_reg)
      `AWRC_MSG_PROMPT:
      begin
        tpl = `AWRC_TPL_PROMPT;
        len = `AWRC_LEN_PROMPT;
      end
      `AWRC_MSG_STOP:
      begin
        tpl = `AWRC_TPL_STOP;
        len = `AWRC_LEN_STOP;
      end
      `AWRC_MSG_END:
      begin
        tpl = `AWRC_TPL_END;
        len = `AWRC_LEN_END;
      end
      default:
      begin
        tpl = `AWRC_TPL_DUMP;
        len = `AWRC_LEN_DUMP;
      end
    endcase
  end

  // strings sit right-aligned, so the first character is the highest byte
  assign pos = len - 6'h01 - idx_reg;
  assign tch = tpl[{pos, 3'b000} +: 8];
  assign nib = data_reg[71:68];
  assign hch = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_reg <= 1'b0;
      idx_reg <= 6'h00;
      msg_reg <= 2'h0;
      data_reg <= 72'h0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy_reg)
      begin
        busy_reg <= 1'b1;
        idx_reg <= 6'h00;
        msg_reg <= msg;
        data_reg <= data;
      end
      else if (busy_reg && (!tx_valid || tx_ready))
      begin
        if (idx_reg == len)
        begin
          busy_reg <= 1'b0;
          tx_valid <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          tx_valid <= 1'b1;
          idx_reg <= idx_reg + 6'h01;
          if (tch == `AWRC_CH_HASH)
          begin
            tx_data <= hch;
            data_reg <= {data_reg[67:0], 4'h0};
          end
          else
          begin
            tx_data <= tch;
          end
        end
      end
      else if (tx_ready)
      begin
        tx_valid <= 1'b0;
      end
    end
  end
endmodule // awrc_emit
`default_nettype wire

// File: testbench/awrc_properties.sv
// port checker for the run control block
`timescale 1ns/1ps
`default_nettype none
`include "awrc_defs.vh"
module awrc_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic bus_valid,
  input wire logic instr_done,
  input wire logic brk_hit,
  input wire logic wai_seen,
  input wire logic irq_unmasked,
  input wire logic abort_switch_pin,
  input wire logic sync_trigger,
  input wire logic run_free,
  input wire logic step_one,
  input wire logic restart_irq,
  input wire logic pc_load,
  input wire logic monitor_debug_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence prompt_start;
    tx_valid && tx_data == `AWRC_CH_CR;
  endsequence
  sequence go_key;
    $past(rx_valid) && $past(rx_data) == `AWRC_CH_G;
  endsequence
  scope_hit_a: assert property (sync_trigger |-> $past(bus_valid))
    else $error("trigger without bus cycle");
  addr_go_a: assert property (pc_load |-> go_key)
    else $error("counter load without go key");
  restart_go_a: assert property (restart_irq |-> go_key)
    else $error("restart without go key");
  run_quiet_a: assert property (run_free |-> !step_one)
    else $error("step pulse during free run");
  step_single_a: assert property (step_one |=> !step_one)
    else $error("step pulse too long");
  // abort passes a synchroniser first, so its cause lies a few cycles back
  run_stop_a: assert property ($fell(run_free) |-> $past(instr_done) || $past(wai_seen) || $past(brk_hit)
    || $past(brk_hit, 2) || $past(abort_switch_pin, 3)) else $error("run ended without cause");
  wai_halt_a: assert property (wai_seen && run_free |=> !run_free)
    else $error("halt opcode did not stop run");
  run_resume_a: assert property ($rose(run_free) |-> $past(irq_unmasked) || $past(rx_valid))
    else $error("run began without cause");
  monitor_off_a: assert property ($rose(run_free) |=> !monitor_debug_mode)
    else $error("monitor kept cpu in free run");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("character dropped before accept");
  reset_prompt_a: assert property ($fell(rst) |-> ##[1:12] prompt_start)
    else $error("no prompt after reset");
endmodule // awrc_properties
bind awrc_top awrc_properties chk (.clk, .rst, .rx_data, .rx_valid, .tx_ready, .tx_data, .tx_valid, .bus_valid,
  .instr_done, .brk_hit, .wai_seen, .irq_unmasked, .abort_switch_pin, .sync_trigger, .run_free, .step_one,
  .restart_irq, .pc_load, .monitor_debug_mode);
`default_nettype wire

// File: testbench/awrc_term.sv
// terminal operator model: types keys, collects printed text
`timescale 1ns/1ps
`default_nettype none
module awrc_term
(
  input wire logic clk,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  logic [7:0] got[$];
  initial
  begin
    tx_ready = 1'h0;
    rx_data = 8'h00;
    rx_valid = 1'h0;
  end
  // random stalls; a character counts only on an accepting edge
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= ($urandom_range(0, 1) == 1);
  end
  // idle data is inverted so a stale key never looks valid
  task automatic keys(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge clk);
      rx_valid <= 1'h1;
      rx_data <= s[i];
      @(posedge clk);
      rx_valid <= 1'h0;
      rx_data <= ~s[i];
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // awrc_term
`default_nettype wire

// File: testbench/awrc_top_test.sv
// self-checking bench for the run control block
`timescale 1ns/1ps
`default_nettype none
module awrc_top_test;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic bus_valid = 1'h0, instr_done = 1'h0, brk_hit = 1'h0, wai_seen = 1'h0, kick = 1'h0;
  logic irq_unmasked = 1'h0, scope = 1'h0, abort = 1'h0;
  logic [15:0] bus_addr = 16'h0000, instr_addr = 16'h0000, cpu_pc = 16'h0000;
  logic [15:0] reg_pc = 16'h0000, reg_x = 16'h0000, reg_sp = 16'h0000;
  logic [7:0] reg_a = 8'h00, reg_b = 8'h00, reg_cc = 8'h00;
  wire [7:0] rx_data, tx_data;
  wire [15:0] pc_value;
  wire rx_valid, tx_ready, tx_valid, sync_trigger, run_free, step_one, restart_irq, pc_load, monitor_debug_mode;
  int miscompares = 0, n_tests = 0, cycles = 0, n_sync = 0, n_step = 0, n_rirq = 0, n_pcl = 0;
  string steps[3] = '{"N", ";N", "3;N"};
  int cnt[3] = '{1, 1, 3};
  always #50 clk = ~clk;
  awrc_top dut (.clk, .rst, .rx_data, .rx_valid, .tx_ready, .tx_data, .tx_valid, .bus_addr, .bus_valid,
    .instr_done, .instr_addr, .brk_hit, .brk_addr(bus_addr), .wai_seen, .irq_unmasked, .reg_pc, .reg_x,
    .reg_a, .reg_b, .reg_cc, .reg_sp, .scope_switch_pin(scope), .abort_switch_pin(abort), .sync_trigger,
    .run_free, .step_one, .restart_irq, .pc_load, .pc_value, .monitor_debug_mode);
  awrc_term term (.clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid);
  // cpu stand-in: one instruction per step pulse or per kick
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      report_and_stop();
    end
    n_sync <= n_sync + sync_trigger;
    n_step <= n_step + step_one;
    n_rirq <= n_rirq + restart_irq;
    n_pcl <= n_pcl + pc_load;
    instr_done <= step_one || kick;
    instr_addr <= cpu_pc;
    if (step_one)
      cpu_pc <= cpu_pc + 16'h0002;
    if (pc_load)
      cpu_pc <= pc_value;
  end
  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic expect_text(input string s);
    bit ok;
    ok = 1'b1;
    repeat (6000) if (term.got.size() < s.len()) @(posedge clk);
    repeat (4) @(posedge clk);
    ok = (term.got.size() == s.len());
    for (int i = 0; i < s.len(); i++)
      ok &= (term.got.size() > i) && (term.got[i] === s[i]);
    term.got.delete();
    check(ok, "printed text");
  endtask
  function automatic string hx(input logic [15:0] v, input int w);
    string s;
    s = $sformatf("%h", v);
    s = s.toupper();
    return s.substr(4 - w, 3);
  endfunction
  function automatic string dump();
    return {"\r\nP-", hx(reg_pc, 4), " X-", hx(reg_x, 4), " A-", hx(reg_a, 2), " B-", hx(reg_b, 2),
      " C-", hx(reg_cc, 2), " S-", hx(reg_sp, 4)};
  endfunction
  // k selects the event: 0 bus cycle, 1 breakpoint, 2 halt opcode, 3 instruction end
  task automatic pulse(input int k, input logic [15:0] a);
    @(posedge clk);
    {kick, wai_seen, brk_hit, bus_valid} <= 4'h1 << k;
    bus_addr <= a;
    @(posedge clk);
    {kick, wai_seen, brk_hit, bus_valid} <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    string t;
    void'($urandom(61376));
    {reg_pc, reg_x, reg_sp, reg_a, reg_b, reg_cc} = {$urandom, $urandom, 8'($urandom)};
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    expect_text("\r\n*");
    scope <= 1'h1;
    term.keys("$S");
    expect_text("\r\nSTOP ADDR 0000 ");
    term.keys("1234\r");
    expect_text("\r\n*");
    pulse(0, 16'h1235);
    pulse(0, 16'h1234);
    check(n_sync === 1 && run_free === 1'h0, "scope pulse");
    $display("test scope done");
    scope <= 1'h0;
    term.keys("10;G");
    repeat (3) @(posedge clk);
    check(n_pcl === 1 && pc_value === 16'h0010 && run_free === 1'h1, "addressed go");
    pulse(0, 16'h1234);
    check(run_free === 1'h1 && n_sync === 1, "instruction finishes first");
    pulse(3, 16'h0000);
    expect_text({dump(), "\r\n*"});
    check(run_free === 1'h0 && monitor_debug_mode === 1'h1, "stop on watch");
    scope <= 1'h1;
    term.keys(";S");
    expect_text("\r\n*");
    pulse(0, 16'h1234);
    check(n_sync === 1, "no pulse after clear");
    term.keys("$S");
    expect_text("\r\nSTOP ADDR 1234 ");
    term.keys("99\r");
    expect_text("\r\n*");
    pulse(0, 16'h0099);
    check(n_sync === 2, "short address entry");
    $display("test watch done");
    term.keys(";G");
    repeat (3) @(posedge clk);
    check(n_rirq === 1 && run_free === 1'h1, "restart go");
    pulse(1, 16'h0000);
    pulse(2, 16'h0000);
    check(run_free === 1'h0, "halt opcode waits");
    irq_unmasked <= 1'h1;
    repeat (3) @(posedge clk);
    irq_unmasked <= 1'h0;
    check(run_free === 1'h1, "interrupt resumes");
    abort <= 1'h1;
    repeat (6) @(posedge clk);
    abort <= 1'h0;
    expect_text("\r\n*");
    check(run_free === 1'h0 && monitor_debug_mode === 1'h1, "abort");
    term.keys("2;P");
    pulse(1, 16'h0020);
    check(run_free === 1'h1 && term.got.size() == 0, "breakpoint bypassed");
    pulse(1, 16'h0020);
    expect_text({dump(), "\r\n*"});
    term.keys(";P");
    repeat (3) @(posedge clk);
    check(run_free === 1'h1 && n_pcl === 1 && n_rirq === 1, "proceed");
    pulse(1, 16'h0020);
    expect_text({dump(), "\r\n*"});
    $display("test free run done");
    foreach (steps[i])
    begin
      term.keys(steps[i]);
      t = "";
      repeat (cnt[i]) t = {t, dump()};
      expect_text({t, "\r\n*"});
    end
    check(n_step === 5, "step count");
    term.keys("$T");
    expect_text("\r\nEND ADDR 0000 ");
    term.keys("14\r");
    expect_text("\r\n*");
    term.keys("10;G");
    expect_text({dump(), dump(), dump(), "\r\n*"});
    check(n_step === 8 && run_free === 1'h0, "trace to end");
    term.keys(";T");
    expect_text("\r\n*");
    term.keys("10;G");
    repeat (3) @(posedge clk);
    check(run_free === 1'h1 && n_step === 8, "trace disarmed");
    $display("test trace done");
    report_and_stop();
  end
endmodule // awrc_top_test
`default_nettype wire
